// file: verilog/hswk_pkg.sv
// package for the halt/sleep wake-up clock control block
// assumes a single system clock domain and a plain register port
package hswk_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] HSWK_ADDR_CFG = 4'h0;
    localparam logic [3:0] HSWK_ADDR_STATUS = 4'h1;
    localparam logic [3:0] HSWK_ADDR_WDT = 4'h2;
    // ------------------------------------------------------------
    // config field layout
    // ------------------------------------------------------------
    localparam int HSWK_SRC_LSB = 0;
    localparam int HSWK_DIV_LSB = 4;
    localparam int HSWK_WSRC_LSB = 8;
    localparam int HSWK_WDIV_LSB = 12;
    localparam int HSWK_RELOAD_BIT = 15;
    localparam logic [15:0] HSWK_CFG_RESET = 16'h0000;
    localparam logic [15:0] HSWK_CFG_MASK = 16'hB333;
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    localparam int HSWK_WDT_WIDTH = 10;
    localparam logic [15:0] HSWK_WDT_KICK = 16'hA5A5;
    localparam logic [15:0] HSWK_WDT_ENABLE = 16'h0001;
    localparam logic [15:0] HSWK_WDT_DISABLE = 16'h0000;
    // power modes
    typedef enum logic [1:0] {
        HSWK_RUN,
        HSWK_HALT,
        HSWK_SLEEP
    } hswk_mode_t;
endpackage

// file: verilog/hswk_wdt.sv
// watchdog counter: counts tick enables, requests reset on overflow
// assumes tick is a one-cycle enable from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module hswk_wdt
    import hswk_pkg::*;
#(
    parameter int WIDTH = HSWK_WDT_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic kick,
    input wire logic tick,
    output logic resetReq
);
    logic [WIDTH-1:0] count_q;

    // ------------------------------------------------------------
    // counter and overflow
    // ------------------------------------------------------------
    // R7: overflow requests reset
    always_ff @(posedge clock) begin
        if (rst || kick || !enable) begin
            count_q <= '0;
            resetReq <= 1'b0;
        end else begin
            resetReq <= 1'b0;
            if (tick) begin
                count_q <= count_q + 1'b1;
                // no nmi option: overflow always means reset
                resetReq <= &count_q;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/hswk_top.sv
// halt/sleep wake-up control with clock reload and watchdog
// assumes cpu mode requests and interrupt levels are same-clock logic
// Function
// R1: any peripheral irq, nmi or debug irq in halt/sleep raises cancel
// R2: wake-up happens whether or not the cpu accepts the interrupt
// R3: at sleep wake-up, clock source loads from wake source field
// R4: with reload enable clear, wake source field has no effect
// R5: software must not pick a stopped source for wake-up
// R6: software should clear reload rather than reprogram same values
// R7: watchdog overflow always raises a reset request
// R8: with reload enabled, clock divider loads from wake divider field; the code loads it only at sleep wake-up, not at halt wake-up
`timescale 1ns/1ps
`default_nettype none
module hswk_top
    import hswk_pkg::*;
#(
    parameter int IRQ_COUNT = 8,
    parameter int WDT_WIDTH = HSWK_WDT_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic haltReq,
    input wire logic sleepReq,
    input wire logic [IRQ_COUNT-1:0] periphIrq,
    input wire logic nmiReq,
    input wire logic debugIrq,
    input wire logic wdtTick,
    output logic cancelPulse,
    output logic cpuRun,
    output logic [1:0] systemClockSourceSelect,
    output logic [1:0] systemClockDividerSelect,
    output logic wdtResetReq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hswk_mode_t mode_q;
    logic [15:0] cfg_q;
    logic wdtEnable_q;
    logic wakeSeen_q;
    logic wdtKick;
    logic wdtReq;
    logic wakeEvent;
    logic reloadNow;

    function automatic logic [1:0] fieldAt(input logic [15:0] w,
                                           input int lsb);
        fieldAt = w[lsb +: 2];
    endfunction

    // R1: any source raises cancel
    // R2: no gating by cpu acceptance
    assign wakeEvent = (|periphIrq) | nmiReq | debugIrq;
    // R4: reload only with enable set
    assign reloadNow = (mode_q == HSWK_SLEEP) && wakeEvent
                       && cfg_q[HSWK_RELOAD_BIT];
    assign wdtKick = regWrite && (regAddr == HSWK_ADDR_WDT)
                     && (regWrData == HSWK_WDT_KICK);

    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    // R1: cancel ends halt or sleep
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= HSWK_RUN;
            cancelPulse <= 1'b0;
            cpuRun <= 1'b1;
        end else begin
            cancelPulse <= 1'b0;
            case (mode_q)
                HSWK_RUN: begin
                    // sleep wins if both requested in one cycle
                    if (sleepReq) begin
                        mode_q <= HSWK_SLEEP;
                        cpuRun <= 1'b0;
                    end else if (haltReq) begin
                        mode_q <= HSWK_HALT;
                        cpuRun <= 1'b0;
                    end
                end
                HSWK_HALT, HSWK_SLEEP: begin
                    if (wakeEvent) begin
                        mode_q <= HSWK_RUN;
                        cancelPulse <= 1'b1;
                        cpuRun <= 1'b1;
                    end
                end
                default: begin
                    mode_q <= HSWK_RUN;
                    cpuRun <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock configuration register
    // ------------------------------------------------------------
    // hardware reload wins over a write in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q <= HSWK_CFG_RESET;
        end else if (reloadNow) begin
            // R3: source from wake field
            cfg_q[HSWK_SRC_LSB +: 2] <= fieldAt(cfg_q, HSWK_WSRC_LSB);
            // R8: divider from wake field
            cfg_q[HSWK_DIV_LSB +: 2] <= fieldAt(cfg_q, HSWK_WDIV_LSB);
        end else if (regWrite && regAddr == HSWK_ADDR_CFG) begin
            // R5: stopped sources are software's concern
            cfg_q <= regWrData & HSWK_CFG_MASK;
        end
    end

    // drive clock selects from registers
    always_ff @(posedge clock) begin
        if (rst) begin
            systemClockSourceSelect <= HSWK_CFG_RESET[HSWK_SRC_LSB +: 2];
            systemClockDividerSelect <= HSWK_CFG_RESET[HSWK_DIV_LSB +: 2];
        end else if (reloadNow) begin
            systemClockSourceSelect <= fieldAt(cfg_q, HSWK_WSRC_LSB);
            systemClockDividerSelect <= fieldAt(cfg_q, HSWK_WDIV_LSB);
        end else if (regWrite && regAddr == HSWK_ADDR_CFG) begin
            systemClockSourceSelect <= regWrData[HSWK_SRC_LSB +: 2];
            systemClockDividerSelect <= regWrData[HSWK_DIV_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // watchdog control and status
    // ------------------------------------------------------------
    // enable and disable codes via register; any other written value leaves it alone
    always_ff @(posedge clock) begin
        if (rst) begin
            wdtEnable_q <= 1'b0;
        end else if (regWrite && regAddr == HSWK_ADDR_WDT) begin
            if (regWrData == HSWK_WDT_ENABLE) begin
                wdtEnable_q <= 1'b1;
            end else if (regWrData == HSWK_WDT_DISABLE) begin
                wdtEnable_q <= 1'b0;
            end
        end
    end

    // sticky wake flag: set wins over clear
    always_ff @(posedge clock) begin
        if (rst) begin
            wakeSeen_q <= 1'b0;
        end else if (cancelPulse) begin
            wakeSeen_q <= 1'b1;
        end else if (regWrite && regAddr == HSWK_ADDR_STATUS
                     && regWrData[0]) begin
            wakeSeen_q <= 1'b0;
        end
    end

    hswk_wdt #(
        .WIDTH(WDT_WIDTH)
    ) wdtInst (
        .clock(clock),
        .rst(rst),
        .enable(wdtEnable_q),
        .kick(wdtKick),
        .tick(wdtTick),
        .resetReq(wdtReq)
    );

    // R7: reset request registered out
    always_ff @(posedge clock) begin
        if (rst) begin
            wdtResetReq <= 1'b0;
        end else begin
            wdtResetReq <= wdtReq;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // data valid only the cycle after the strobe; zero otherwise
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                HSWK_ADDR_CFG: regRdData <= cfg_q;
                HSWK_ADDR_STATUS: regRdData <= {13'h0000,
                                                mode_q, wakeSeen_q};
                HSWK_ADDR_WDT: regRdData <= {15'h0000, wdtEnable_q};
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// file: bench/hswk_chk.sv
// port checker for the wake-up clock control top
// bound to hswk_top, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module hswk_chk
    import hswk_pkg::*;
#(
    parameter int IRQ_COUNT = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic haltReq,
    input wire logic sleepReq,
    input wire logic [IRQ_COUNT-1:0] periphIrq,
    input wire logic nmiReq,
    input wire logic debugIrq,
    input wire logic wdtTick,
    input wire logic cancelPulse,
    input wire logic cpuRun,
    input wire logic [1:0] systemClockSourceSelect,
    input wire logic [1:0] systemClockDividerSelect,
    input wire logic wdtResetReq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic anyIrq;
    // any wake cause, level sensitive
    assign anyIrq = |periphIrq || nmiReq || debugIrq;
    sequence s_asleep_irq; !cpuRun && anyIrq; endsequence
    sequence s_enter; cpuRun && (sleepReq || haltReq); endsequence
    property p_wake; s_asleep_irq |=> cancelPulse && cpuRun; endproperty
    property p_pulse; cancelPulse |=> !cancelPulse; endproperty
    property p_idle; cancelPulse |-> !$past(cpuRun); endproperty
    property p_enter; s_enter |=> !cpuRun && !cancelPulse; endproperty
    property p_hold; !cpuRun && !anyIrq |=> !cpuRun; endproperty
    // selects move only on a config write or a wake reload
    property p_sel;
        $changed({systemClockSourceSelect, systemClockDividerSelect})
        |-> cancelPulse || $past(regWrite && regAddr == HSWK_ADDR_CFG);
    endproperty
    property p_wdt1; wdtResetReq |=> !wdtResetReq; endproperty
    property p_wdtc; wdtResetReq |-> $past(wdtTick, 2); endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after irq in halt or sleep");
    a_pulse: assert property (p_pulse)
        else $error("cancel longer than one cycle");
    a_idle: assert property (p_idle)
        else $error("cancel raised while running");
    a_enter: assert property (p_enter)
        else $error("halt or sleep not entered");
    a_hold: assert property (p_hold)
        else $error("woke without a cause");
    a_sel: assert property (p_sel)
        else $error("clock select moved without cause");
    a_wdt1: assert property (p_wdt1)
        else $error("watchdog request too long");
    a_wdtc: assert property (p_wdtc)
        else $error("watchdog request without tick");
endmodule
`default_nettype wire

// file: bench/hswk_cpu_model.sv
// cpu core and interrupt sources facing the wake-up block
// driven by bench task calls, outputs move right after rising edges
`timescale 1ns/1ps
`default_nettype none
module hswk_cpu_model (
    input wire logic clock,
    input wire logic cancelPulse,
    output logic haltReq = 1'b0,
    output logic sleepReq = 1'b0,
    output logic [7:0] periphIrq = 8'h00,
    output logic nmiReq = 1'b0,
    output logic debugIrq = 1'b0
);
    // one-cycle mode request, then one wake source held until cancel
    task nap(input logic slp, input int src, input int lag);
        int n;
        @(posedge clock);
        sleepReq <= slp;
        haltReq <= !slp;
        @(posedge clock);
        sleepReq <= 1'b0;
        haltReq <= 1'b0;
        repeat (lag) @(posedge clock);
        if (src < 8) periphIrq[src] <= 1'b1;
        else if (src == 8) nmiReq <= 1'b1;
        else debugIrq <= 1'b1;
        n = 0;
        while (!cancelPulse && n < 40) begin
            @(posedge clock);
            n++;
        end
        periphIrq <= 8'h00;
        nmiReq <= 1'b0;
        debugIrq <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/hswk_top_test.sv
// self-checking bench: register port, watchdog tick, cpu model
// read results queued and compared by a monitor one cycle later
`timescale 1ns/1ps
`default_nettype none
module hswk_top_test
    import hswk_pkg::*;
;
    logic clock = 0, rst = 1, regWrite = 0, regRead = 0, wdtTick = 0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000, regRdData, d, cfg;
    logic haltReq, sleepReq, nmiReq, debugIrq, cancelPulse, cpuRun;
    logic wdtResetReq, pend = 0;
    logic [7:0] periphIrq;
    logic [1:0] srcSel, divSel;
    logic [15:0] expQ[$];
    int mismatches = 0, num_checks = 0, resets = 0;
    always #12.5 clock = ~clock;
    hswk_top #(.IRQ_COUNT(8), .WDT_WIDTH(3)) i_dut (.clock(clock),
        .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .haltReq(haltReq), .sleepReq(sleepReq), .periphIrq(periphIrq),
        .nmiReq(nmiReq), .debugIrq(debugIrq), .wdtTick(wdtTick),
        .cancelPulse(cancelPulse), .cpuRun(cpuRun),
        .systemClockSourceSelect(srcSel),
        .systemClockDividerSelect(divSel), .wdtResetReq(wdtResetReq));
    hswk_cpu_model i_cpu (.clock(clock), .cancelPulse(cancelPulse),
        .haltReq(haltReq), .sleepReq(sleepReq), .periphIrq(periphIrq),
        .nmiReq(nmiReq), .debugIrq(debugIrq));
    task chk16(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // one strobe cycle; for a read v is the expected data
    task bus(input logic w, input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        regAddr <= a;
        regWrData <= v;
        regWrite <= w;
        regRead <= !w;
        if (!w) expQ.push_back(v);
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask
    // n back-to-back ticks, then let the request pipeline drain
    task tick(input int n);
        @(posedge clock);
        wdtTick <= 1'b1;
        repeat (n) @(posedge clock);
        wdtTick <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // read data lands one cycle after the strobe edge
    always @(posedge clock) begin
        if (pend) chk16("read", expQ.pop_front(), regRdData);
        pend <= regRead;
        if (wdtResetReq) resets++;
    end
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(24342));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        bus(0, HSWK_ADDR_CFG, HSWK_CFG_RESET);
        bus(0, HSWK_ADDR_STATUS, 16'h0000);
        bus(0, 4'hF, 16'h0000);
        // every source counts as running in this bench
        for (int i = 0; i < 10; i++) begin
            d = 16'($urandom()) & HSWK_CFG_MASK;
            d[9:8] = d[1:0] ^ 2'h1;
            d[15] = i[0];
            bus(1, HSWK_ADDR_CFG, d);
            bus(0, HSWK_ADDR_CFG, d);
            cfg = d;
            if (i[1] && d[15]) begin
                cfg[1:0] = d[9:8];
                cfg[5:4] = d[13:12];
            end
            i_cpu.nap(i[1], i, int'($urandom_range(3, 0)));
            @(negedge clock);
            chk16("source", {14'h0, cfg[1:0]}, {14'h0, srcSel});
            chk16("divider", {14'h0, cfg[5:4]}, {14'h0, divSel});
            bus(0, HSWK_ADDR_CFG, cfg);
            bus(0, HSWK_ADDR_STATUS, 16'h0001);
            bus(1, HSWK_ADDR_STATUS, 16'h0001);
        end
        bus(0, HSWK_ADDR_STATUS, 16'h0000);
        bus(1, HSWK_ADDR_WDT, HSWK_WDT_ENABLE);
        bus(0, HSWK_ADDR_WDT, 16'h0001);
        tick(8);
        tick(7);
        bus(1, HSWK_ADDR_WDT, HSWK_WDT_KICK);
        tick(7);
        chk16("resets", 16'h0001, 16'(resets));
        tick(1);
        chk16("resets", 16'h0002, 16'(resets));
        bus(1, HSWK_ADDR_WDT, HSWK_WDT_DISABLE);
        tick(8);
        chk16("resets", 16'h0002, 16'(resets));
        test_done;
    end
endmodule
bind hswk_top hswk_chk #(.IRQ_COUNT(IRQ_COUNT)) u_chk (.clock(clock),
    .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .haltReq(haltReq),
    .sleepReq(sleepReq), .periphIrq(periphIrq), .nmiReq(nmiReq),
    .debugIrq(debugIrq), .wdtTick(wdtTick), .cancelPulse(cancelPulse),
    .cpuRun(cpuRun), .systemClockSourceSelect(systemClockSourceSelect),
    .systemClockDividerSelect(systemClockDividerSelect),
    .wdtResetReq(wdtResetReq));
`default_nettype wire
